// File: analog_clk_pkg.sv
// Shared constants for the analog column clock and reference control block.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing and a
// single 100 MHz system clock.
package analog_clk_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W   = 12;       // Register bus address width
  localparam int unsigned DATA_W   = 32;       // Register bus data width
  localparam int unsigned REG_W    = 8;        // Width of every byte register

  // ---------------------------------------------------------------------------
  // Register indexes (as printed) and byte addresses (four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] COLUMN_CLOCK_SELECT_IDX      = 12'h060;
  localparam logic [ADDR_W-1:0] ROUTED_CLOCK_SELECT_IDX      = 12'h061;
  localparam logic [ADDR_W-1:0] ANALOG_REFERENCE_CONTROL_IDX = 12'h063;
  localparam logic [ADDR_W-1:0] CLOCK_STATUS_IDX             = 12'h064;
  localparam logic [ADDR_W-1:0] COLUMN_CLOCK_SELECT_ADDR      = {COLUMN_CLOCK_SELECT_IDX[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ROUTED_CLOCK_SELECT_ADDR      = {ROUTED_CLOCK_SELECT_IDX[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ANALOG_REFERENCE_CONTROL_ADDR = {ANALOG_REFERENCE_CONTROL_IDX[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] CLOCK_STATUS_ADDR             = {CLOCK_STATUS_IDX[ADDR_W-3:0], 2'h0};

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [REG_W-1:0] COLUMN_CLOCK_SELECT_RST      = 8'h00;
  localparam logic [REG_W-1:0] ROUTED_CLOCK_SELECT_RST      = 8'h00;
  localparam logic [REG_W-1:0] ANALOG_REFERENCE_CONTROL_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned COL_SEL_W          = 2;  // Bits per column source field
  localparam int unsigned ROUTED_SEL_W       = 3;  // Bits per routed clock field
  localparam int unsigned ROUTED_FIRST_LSB   = 0;  // First routed clock select [2:0]
  localparam int unsigned ROUTED_SECOND_LSB  = 3;  // Second routed clock select [5:3]
  localparam int unsigned SAMPLE_HOLD_BIT    = 6;  // Sample-and-hold disable
  localparam int unsigned POWER_LSB          = 0;  // Array power code [2:0]
  localparam int unsigned REF_CFG_LSB        = 3;  // Reference configuration [5:3]
  localparam int unsigned HIGH_BIAS_BIT      = 6;  // Bias level select
  localparam int unsigned BANDGAP_TEST_BIT   = 7;  // Factory bandgap test
  localparam int unsigned STATUS_ROUTED_LSB  = 4;  // Routed clock levels in status

  // ---------------------------------------------------------------------------
  // Column source encodings and array sizes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SRC_SYSTEM_FIRST  = 2'h0;
  localparam logic [1:0] SRC_SYSTEM_SECOND = 2'h1;
  localparam logic [1:0] SRC_ROUTED_FIRST  = 2'h2;
  localparam logic [1:0] SRC_ROUTED_SECOND = 2'h3;
  localparam int unsigned NUM_COLUMNS      = 4;  // Analog columns
  localparam int unsigned NUM_DIG_BLOCKS   = 8;  // Digital peripheral blocks
  localparam int unsigned DIV_CNT_W        = 2;  // Divide by four counter
  localparam int unsigned SYNC_STAGES      = 2;  // Synchroniser depth

  // ---------------------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : analog_clk_pkg

// File: column_clk_if.sv
// Carries one column's source clocks, select code and divided clock.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ns
interface column_clk_if;
  logic [3:0] src_levels;   // Synchronised sources, index = select code
  logic [1:0] src_select;   // Column source select field
  logic       div_clk;      // Divided column clock (registered)

  modport ctrl (output src_levels, output src_select, input div_clk);
  modport div  (input src_levels, input src_select, output div_clk);
endinterface : column_clk_if

// File: column_clk_divider.sv
// Divide-by-four stage for one analog column.
// Assumes its source levels are already synchronised to i_clk_sys.
`timescale 1ns/1ns
module column_clk_divider #(
  parameter int unsigned CNT_W = analog_clk_pkg::DIV_CNT_W
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  column_clk_if.div col
);

  // ---------------------------------------------------------------------------
  // Source selection and edge detect
  // ---------------------------------------------------------------------------
  logic             chosen;     // Currently selected source level
  logic             chosen_d;   // Previous sample for edge detection
  logic [CNT_W-1:0] div_cnt;    // Free-running quarter counter

  // Pick one of four sources by the 2-bit code
  always_comb begin
    chosen = col.src_levels[col.src_select];
  end

  // Remember last level of the chosen source
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chosen_d <= 1'b0;
    end else begin
      chosen_d <= chosen;
    end
  end

  // ---------------------------------------------------------------------------
  // Counter: top bit is a 50 percent clock at a quarter of the source
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt <= '0;
    end else if (chosen && !chosen_d) begin
      div_cnt <= div_cnt + CNT_W'(1);
    end
  end

  // Registered output so the column clock comes from a flip-flop
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      col.div_clk <= 1'b0;
    end else begin
      col.div_clk <= div_cnt[CNT_W-1];
    end
  end

endmodule : column_clk_divider

// File: analog_column_clock_and_ref_ctrl.sv
// Analog column clock routing and reference/bias/power control registers.
// Assumes an AXI4-Lite master on i_clk_sys and clock sources that are
// asynchronous levels, sampled here and rebuilt as divided column clocks.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module analog_column_clock_and_ref_ctrl #(
  parameter int unsigned NUM_COLUMNS    = analog_clk_pkg::NUM_COLUMNS,
  parameter int unsigned NUM_DIG_BLOCKS = analog_clk_pkg::NUM_DIG_BLOCKS
) (
  input  wire logic                               i_clk_sys,
  input  wire logic                               i_rst_n,
  // AXI4-Lite write address channel
  input  wire logic [analog_clk_pkg::ADDR_W-1:0]  i_s_axi_awaddr,
  input  wire logic [2:0]                         i_s_axi_awprot,
  input  wire logic                               i_s_axi_awvalid,
  output      logic                               o_s_axi_awready,
  // AXI4-Lite write data channel
  input  wire logic [analog_clk_pkg::DATA_W-1:0]  i_s_axi_wdata,
  input  wire logic [3:0]                         i_s_axi_wstrb,
  input  wire logic                               i_s_axi_wvalid,
  output      logic                               o_s_axi_wready,
  // AXI4-Lite write response channel
  output      logic [1:0]                         o_s_axi_bresp,
  output      logic                               o_s_axi_bvalid,
  input  wire logic                               i_s_axi_bready,
  // AXI4-Lite read address channel
  input  wire logic [analog_clk_pkg::ADDR_W-1:0]  i_s_axi_araddr,
  input  wire logic [2:0]                         i_s_axi_arprot,
  input  wire logic                               i_s_axi_arvalid,
  output      logic                               o_s_axi_arready,
  // AXI4-Lite read data channel
  output      logic [analog_clk_pkg::DATA_W-1:0]  o_s_axi_rdata,
  output      logic [1:0]                         o_s_axi_rresp,
  output      logic                               o_s_axi_rvalid,
  input  wire logic                               i_s_axi_rready,
  // Clock sources (asynchronous to i_clk_sys)
  input  wire logic                               i_system_clk_first,
  input  wire logic                               i_system_clk_second,
  input  wire logic [NUM_DIG_BLOCKS-1:0]          i_digital_block_clk,
  // Clock outputs
  output      logic                               o_routed_clk_first,
  output      logic                               o_routed_clk_second,
  output      logic [NUM_COLUMNS-1:0]             o_column_clk,
  // Analog array controls
  output      logic                               o_high_bias_row_first,
  output      logic                               o_high_bias_rows_rest,
  output      logic [2:0]                         o_reference_config_code,
  output      logic                               o_reference_config_reserved,
  output      logic                               o_all_analog_off,
  output      logic                               o_switched_cap_blocks_on,
  output      logic [1:0]                         o_level_buffer_drive,
  output      logic                               o_bandgap_test_bit,
  output      logic                               o_sample_hold_disable
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  localparam int unsigned SRC_N = NUM_DIG_BLOCKS + 2;  // All sampled sources

  logic [7:0]                        column_clock_select;       // Column source fields
  logic [7:0]                        routed_clock_select;       // Routed clock fields
  logic [7:0]                        analog_reference_control;  // Ref/bias/power
  logic [SRC_N-1:0]                  src_meta;                  // First sync stage
  logic [SRC_N-1:0]                  src_sync;                  // Second sync stage
  logic [analog_clk_pkg::ADDR_W-1:0] wr_addr;                   // Held write address
  logic [7:0]                        wr_data;                   // Held write byte
  logic                              wr_lane0;                  // Held byte-lane 0 strobe
  logic                              aw_held;                   // Write address captured
  logic                              w_held;                    // Write data captured
  logic                              do_write;                  // Both halves present
  logic                              wr_hit;                    // Write targets a mapped register
  logic [7:0]                        next_rdata;                // Read mux output
  logic                              next_rd_hit;               // Read address mapped
  logic [7:0]                        clock_status;              // Live clock levels
  logic [2:0]                        power_code;                // Array power field

  // ---------------------------------------------------------------------------
  // Two-stage synchroniser on every clock source
  // ---------------------------------------------------------------------------
  // Stage one feeds stage two only
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_meta <= '0;
      src_sync <= '0;
    end else begin
      src_meta <= {i_system_clk_second, i_system_clk_first, i_digital_block_clk};
      src_sync <= src_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // Routed clocks: any of the eight digital blocks
  // ---------------------------------------------------------------------------
  // Index 0..3 are basic blocks, 4..7 communication blocks
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_routed_clk_first  <= 1'b0;
      o_routed_clk_second <= 1'b0;
    end else begin
      o_routed_clk_first  <= src_sync[routed_clock_select[analog_clk_pkg::ROUTED_FIRST_LSB +: 3]];
      o_routed_clk_second <= src_sync[routed_clock_select[analog_clk_pkg::ROUTED_SECOND_LSB +: 3]];
    end
  end

  // ---------------------------------------------------------------------------
  // Column clocks: one divider per column, shared by every block in it
  // ---------------------------------------------------------------------------
  for (genvar c = 0; c < NUM_COLUMNS; c++) begin : g_column
    column_clk_if col_if ();

    // Source vector ordered by select code
    assign col_if.src_levels = {o_routed_clk_second, o_routed_clk_first,
                                src_sync[NUM_DIG_BLOCKS+1], src_sync[NUM_DIG_BLOCKS]};
    // Field c occupies bits 2c+1:2c
    assign col_if.src_select = column_clock_select[c*2 +: 2];

    column_clk_divider #(
      .CNT_W (analog_clk_pkg::DIV_CNT_W)
    ) u_div (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .col       (col_if.div)
    );

    // Single clock for the whole column, no per-block choice
    assign o_column_clk[c] = col_if.div_clk;
  end

  // ---------------------------------------------------------------------------
  // Analog array controls, registered from the reference control register; sample-and-hold disable from the routed clock select register
  // ---------------------------------------------------------------------------
  assign power_code = analog_reference_control[analog_clk_pkg::POWER_LSB +: 3];

  // Bias: one line for row one, one line shared by rows two and three
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_high_bias_row_first <= 1'b0;
      o_high_bias_rows_rest <= 1'b0;
    end else begin
      o_high_bias_row_first <= analog_reference_control[analog_clk_pkg::HIGH_BIAS_BIT];
      o_high_bias_rows_rest <= analog_reference_control[analog_clk_pkg::HIGH_BIAS_BIT];
    end
  end

  // Reference configuration code and reserved-code flag
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reference_config_code     <= 3'h0;
      o_reference_config_reserved <= 1'b0;
    end else begin
      o_reference_config_code     <= analog_reference_control[analog_clk_pkg::REF_CFG_LSB +: 3];
      // Codes 6 and 7 have no defined reference
      o_reference_config_reserved <= analog_reference_control[analog_clk_pkg::REF_CFG_LSB + 2] &
                                     analog_reference_control[analog_clk_pkg::REF_CFG_LSB + 1];
    end
  end

  // Power decode: code 0 all off, bit 2 enables SC blocks, low bits give drive
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_all_analog_off         <= 1'b1;
      o_switched_cap_blocks_on <= 1'b0;
      o_level_buffer_drive     <= 2'h0;
    end else begin
      o_all_analog_off         <= (power_code == 3'h0);
      o_switched_cap_blocks_on <= power_code[2];
      o_level_buffer_drive     <= power_code[1:0];
    end
  end

  // Factory test bit and sample-and-hold flag are passed through as stored
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bandgap_test_bit    <= 1'b0;
      o_sample_hold_disable <= 1'b0;
    end else begin
      // Relies on software keeping this bit at zero
      o_bandgap_test_bit    <= analog_reference_control[analog_clk_pkg::BANDGAP_TEST_BIT];
      o_sample_hold_disable <= routed_clock_select[analog_clk_pkg::SAMPLE_HOLD_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------------------
  assign do_write = aw_held && w_held && !o_s_axi_bvalid;
  assign wr_hit   = (wr_addr == analog_clk_pkg::COLUMN_CLOCK_SELECT_ADDR) ||
                    (wr_addr == analog_clk_pkg::ROUTED_CLOCK_SELECT_ADDR) ||
                    (wr_addr == analog_clk_pkg::ANALOG_REFERENCE_CONTROL_ADDR) ||
                    (wr_addr == analog_clk_pkg::CLOCK_STATUS_ADDR);

  // Address channel: take once, hold until the response is accepted
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_awready <= 1'b1;
      aw_held         <= 1'b0;
      wr_addr         <= '0;
    end else if (o_s_axi_awvalid_take()) begin
      o_s_axi_awready <= 1'b0;
      aw_held         <= 1'b1;
      wr_addr         <= {i_s_axi_awaddr[analog_clk_pkg::ADDR_W-1:2], 2'h0};
    end else if (do_write) begin
      aw_held         <= 1'b0;
    end else if (o_s_axi_bvalid && i_s_axi_bready) begin
      o_s_axi_awready <= 1'b1;
    end
  end

  // Handshake helper for the address channel
  function automatic logic o_s_axi_awvalid_take();
    return i_s_axi_awvalid && o_s_axi_awready;
  endfunction : o_s_axi_awvalid_take

  // Data channel: take once, hold until the response is accepted
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_wready <= 1'b1;
      w_held         <= 1'b0;
      wr_data        <= 8'h00;
      wr_lane0       <= 1'b0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      o_s_axi_wready <= 1'b0;
      w_held         <= 1'b1;
      wr_data        <= i_s_axi_wdata[7:0];
      wr_lane0       <= i_s_axi_wstrb[0];
    end else if (do_write) begin
      w_held         <= 1'b0;
    end else if (o_s_axi_bvalid && i_s_axi_bready) begin
      o_s_axi_wready <= 1'b1;
    end
  end

  // Response: OKAY for mapped, SLVERR for unmapped
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= analog_clk_pkg::RESP_OKAY;
    end else if (do_write) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp  <= wr_hit ? analog_clk_pkg::RESP_OKAY : analog_clk_pkg::RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Register storage; lane 0 only, upper lanes ignored
  // ---------------------------------------------------------------------------
  // Column clock select register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      column_clock_select <= analog_clk_pkg::COLUMN_CLOCK_SELECT_RST;
    end else if (do_write && wr_lane0 && wr_addr == analog_clk_pkg::COLUMN_CLOCK_SELECT_ADDR) begin
      column_clock_select <= wr_data;
    end
  end

  // Routed clock select register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      routed_clock_select <= analog_clk_pkg::ROUTED_CLOCK_SELECT_RST;
    end else if (do_write && wr_lane0 && wr_addr == analog_clk_pkg::ROUTED_CLOCK_SELECT_ADDR) begin
      routed_clock_select <= wr_data;
    end
  end

  // Reference control register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      analog_reference_control <= analog_clk_pkg::ANALOG_REFERENCE_CONTROL_RST;
    end else if (do_write && wr_lane0 && wr_addr == analog_clk_pkg::ANALOG_REFERENCE_CONTROL_ADDR) begin
      analog_reference_control <= wr_data;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------------------
  // Status: column clocks low, routed clocks above, rest zero
  assign clock_status = {2'h0, o_routed_clk_second, o_routed_clk_first, o_column_clk[3:0]};

  // Read data mux
  always_comb begin
    next_rdata  = 8'h00;
    next_rd_hit = 1'b1;
    case ({i_s_axi_araddr[analog_clk_pkg::ADDR_W-1:2], 2'h0})
      analog_clk_pkg::COLUMN_CLOCK_SELECT_ADDR:      next_rdata = column_clock_select;
      analog_clk_pkg::ROUTED_CLOCK_SELECT_ADDR:      next_rdata = routed_clock_select;
      analog_clk_pkg::ANALOG_REFERENCE_CONTROL_ADDR: next_rdata = analog_reference_control;
      analog_clk_pkg::CLOCK_STATUS_ADDR:             next_rdata = clock_status;
      default:                                       next_rd_hit = 1'b0;
    endcase
  end

  // Address taken, data presented next cycle, held until accepted
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= '0;
      o_s_axi_rresp   <= analog_clk_pkg::RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rdata   <= {24'h000000, next_rdata};
      o_s_axi_rresp   <= next_rd_hit ? analog_clk_pkg::RESP_OKAY : analog_clk_pkg::RESP_SLVERR;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
    end
  end

endmodule : analog_column_clock_and_ref_ctrl

// File: acc_properties.sv
// Port assertions for the column clock and reference control block.
// Assumes it is bound to that top module and sees only its ports.
`timescale 1ns/1ns
module acc_properties #(parameter int unsigned NUM_COLUMNS = 4) (
  input wire logic i_clk_sys, i_rst_n, i_s_axi_bready, i_s_axi_rready, o_s_axi_bvalid, o_s_axi_rvalid,
  input wire logic o_s_axi_arready, o_high_bias_row_first, o_high_bias_rows_rest, o_reference_config_reserved,
  input wire logic o_all_analog_off, o_switched_cap_blocks_on, input wire logic [1:0] o_level_buffer_drive,
  input wire logic [2:0] o_reference_config_code, input wire logic [31:0] o_s_axi_rdata,
  input wire logic [NUM_COLUMNS-1:0] o_column_clk);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Column clock edge; sources here never rise closer than 8 cycles
  sequence col_toggle; $changed(o_column_clk[0]); endsequence
  a_bias_rows_same: assert property (o_high_bias_row_first == o_high_bias_rows_rest) else $error("bias rows differ");
  a_ref_reserved_flag: assert property (o_reference_config_reserved == (o_reference_config_code[2:1] == 2'h3)) else $error("reserved flag");
  a_power_all_off: assert property (o_all_analog_off == (!o_switched_cap_blocks_on && o_level_buffer_drive == 2'h0)) else $error("power off");
  a_col_div_period: assert property (col_toggle |=> $stable(o_column_clk[0]) [*7]) else $error("column half period short");
  a_bvalid_held: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid) else $error("bvalid dropped");
  a_rdata_held: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("rdata moved");
  a_rdata_upper_zero: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0) else $error("rdata upper bits");
  a_read_one_open: assert property (o_s_axi_rvalid |-> !o_s_axi_arready) else $error("second read accepted");
endmodule : acc_properties
bind analog_column_clock_and_ref_ctrl acc_properties #(.NUM_COLUMNS(NUM_COLUMNS)) chk (.*);

// File: column_sink.sv
// Model of the analog column blocks: measures each column clock period.
// Assumes column clocks are sampled on the system clock.
`timescale 1ns/1ns
module column_sink (
  input  wire logic       i_clk_sys,
  input  wire logic [3:0] i_col,
  output int              o_period [4]);
  logic [3:0] prev;                  // Column levels one cycle ago
  int         run [4] = '{default: 0};  // Cycles since the last rising edge
  // Every block of a column sees the one column clock, so one count each
  always @(posedge i_clk_sys) begin
    prev <= i_col;
    for (int c = 0; c < 4; c++) if (i_col[c] && !prev[c]) begin o_period[c] <= run[c] + 1; run[c] <= 0; end
    else run[c] <= run[c] + 1;
  end
endmodule : column_sink

// File: tb.sv
// Self-checking bench for the column clock and reference control block.
// Assumes clock sources derived from a counter on the system clock.
`timescale 1ns/1ns
module tb;
  logic i_clk_sys = 0, i_rst_n = 0, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
  logic i_s_axi_arvalid = 0, i_s_axi_rready = 0, h, hw, v;
  logic [11:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0, cnt = 0;
  logic [31:0] i_s_axi_wdata = 0, d;
  logic [3:0]  i_s_axi_wstrb = 4'hF;
  logic [2:0]  i_s_axi_awprot = 0, i_s_axi_arprot = 0, o_reference_config_code;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, o_level_buffer_drive, r;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_routed_clk_first;
  logic o_routed_clk_second, o_high_bias_row_first, o_high_bias_rows_rest, o_reference_config_reserved;
  logic o_all_analog_off, o_switched_cap_blocks_on, o_bandgap_test_bit, o_sample_hold_disable;
  logic [31:0] o_s_axi_rdata;
  logic [3:0]  o_column_clk;
  wire logic i_system_clk_first = cnt[2], i_system_clk_second = cnt[3];
  wire logic [7:0] i_digital_block_clk = cnt[11:4];  // Block n period 32<<n cycles
  int n_errors = 0, n_compared = 0, per [4], mx, e;
  logic [7:0] col_rows [4] = '{8'hE4, 8'h1B, 8'hBB, 8'hBB};  // Column select rows
  logic [7:0] rt_rows [4] = '{8'h08, 8'h13, 8'h2C, 8'h3E};   // Routed select rows
  analog_column_clock_and_ref_ctrl DUT (.*);
  column_sink partner (.i_clk_sys(i_clk_sys), .i_col(o_column_clk), .o_period(per));
  initial forever #5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) cnt <= cnt + 12'h1;
  // Expected column period in system cycles
  function automatic int exp_per(logic [1:0] c, logic [7:0] rs);
    return c == 2'h0 ? 32 : c == 2'h1 ? 64 : 128 << (c == 2'h2 ? rs[2:0] : rs[5:3]);
  endfunction : exp_per
  task automatic chk(input string nm, input logic [31:0] ex, seen);
    n_compared++;
    if (seen !== ex) begin n_errors++; $display("[ERR] %s exp %h seen %h", nm, ex, seen); end
  endtask : chk
  task report_and_stop;
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] b);
    @(posedge i_clk_sys); i_s_axi_awaddr <= a; i_s_axi_wdata <= {24'h0, b};
    i_s_axi_awvalid <= 1; i_s_axi_wvalid <= 1; i_s_axi_bready <= 1;
    do begin @(negedge i_clk_sys); h = i_s_axi_awvalid && o_s_axi_awready; hw = i_s_axi_wvalid && o_s_axi_wready;
      v = o_s_axi_bvalid; @(posedge i_clk_sys); if (h) i_s_axi_awvalid <= 0; if (hw) i_s_axi_wvalid <= 0; end while (!v);
    i_s_axi_bready <= 0; r = o_s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge i_clk_sys); i_s_axi_araddr <= a; i_s_axi_arvalid <= 1; i_s_axi_rready <= 1;
    do begin @(negedge i_clk_sys); h = i_s_axi_arvalid && o_s_axi_arready; v = o_s_axi_rvalid; d = o_s_axi_rdata;
      r = o_s_axi_rresp; @(posedge i_clk_sys); if (h) i_s_axi_arvalid <= 0; end while (!v);
    i_s_axi_rready <= 0;
  endtask : rd
  initial begin repeat (60000) @(posedge i_clk_sys); n_errors++; report_and_stop; end
  initial begin
    repeat (10) @(posedge i_clk_sys); i_rst_n <= 1;
    chk("all off", 1, o_all_analog_off);
    rd(analog_clk_pkg::COLUMN_CLOCK_SELECT_ADDR); chk("col sel reset", 0, d);
    rd(analog_clk_pkg::ANALOG_REFERENCE_CONTROL_ADDR); chk("ref reset", 0, d);
    rd(12'h0FC); chk("unmapped resp", analog_clk_pkg::RESP_SLVERR, r);
    wr(12'h0FC, 8'h5A); chk("unmapped bresp", analog_clk_pkg::RESP_SLVERR, r);
    for (int i = 0; i < 4; i++) begin
      wr(analog_clk_pkg::COLUMN_CLOCK_SELECT_ADDR, col_rows[i]); wr(analog_clk_pkg::ROUTED_CLOCK_SELECT_ADDR, rt_rows[i]);
      rd(analog_clk_pkg::COLUMN_CLOCK_SELECT_ADDR); chk("col sel", col_rows[i], d);
      mx = 0;
      for (int c = 0; c < 4; c++) begin e = exp_per(col_rows[i][2*c+:2], rt_rows[i]); if (e > mx) mx = e; end
      repeat (2 * mx + 32) @(posedge i_clk_sys);
      for (int c = 0; c < 4; c++) chk("col period", exp_per(col_rows[i][2*c+:2], rt_rows[i]), per[c]);
    end
    for (int k = 0; k < 8; k++) begin
      wr(analog_clk_pkg::ANALOG_REFERENCE_CONTROL_ADDR, {1'b0, k[0], k[2:0], k[2:0]});
      repeat (2) @(posedge i_clk_sys);
      chk("ref outs", {k == 0, k[2], k[1:0], k[2:0], k >= 6, k[0], 1'b0}, {o_all_analog_off, o_switched_cap_blocks_on,
        o_level_buffer_drive, o_reference_config_code, o_reference_config_reserved, o_high_bias_rows_rest,
        o_bandgap_test_bit});
    end
    wr(analog_clk_pkg::ROUTED_CLOCK_SELECT_ADDR, 8'h40); repeat (2) @(posedge i_clk_sys);
    chk("sh dis", 1, o_sample_hold_disable);
    report_and_stop;
  end
endmodule : tb
